// ==== src/rap_power_dsp.sv ====
/*
  Per-phase reactive and apparent power processing with half-cycle
  line energy accumulation. Assumes samples are signed, synchronous to
  clk_sys, with sampleValid marking one sample set per phase.
*/
// Behaviour
// - Voltage times current delayed by 89 degrees
// - Low-pass each reactive product to dc
// - Total reactive uses summing-mode field bits 7:6
// - Mode 0 sum, 1 and 2 B-referenced formulas
// - Line select bits gate reactive and active terms; apparent sum ungated
// - Reactive uses shifted current samples as given, no gain or filtering
// - Reactive count scaled down by 9.546
// - Waveform bit 5 puts reactive into signed
// - Reactive accumulates over whole half cycles
// - Reactive mode moves active into unsigned accumulator
// - Reactive mode stops apparent line accumulation
// - Active into unsigned summed by magnitude
// - Measurement bits 4..6 select counted crossings
// - Selected phase enables its crossing logic
// - Sixteen-bit half-cycle target, up to 65535
// - End sets flag, irq low if enabled
// - Apparent power is vrms times irms
// - Apparent gain 800h minimum, 7ffh maximum
// - No offset correction in apparent path
`timescale 1ns/1ns
module rap_power_dsp
  import rap_pkg::*;
#(
  parameter int SW = 24,
  parameter int AW = 48,
  parameter int SHIFT_DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [3*SW-1:0] voltSample,
  input wire logic [3*SW-1:0] currSample,
  input wire logic [3*SW-1:0] activeProd,
  input wire logic [3*SW-1:0] voltRms,
  input wire logic [3*SW-1:0] currRms,
  input wire logic [2:0] zeroCross,
  input wire logic [$clog2(SHIFT_DEPTH)-1:0] shiftSlots,
  input wire logic [7:0] waveform_mode_ctrl,
  input wire logic [7:0] power_summing_mode_reg,
  input wire logic [7:0] measurement_mode_reg,
  input wire logic [15:0] half_cycle_target,
  input wire logic [35:0] apparentGain,
  input wire logic halfCycleIrqEn,
  input wire logic halfCycleFlagClr,
  output logic [3*SW-1:0] reactivePower,
  output logic [3*SW-1:0] apparentPower,
  output logic [SW+1:0] totalApparent,
  output logic [AW-1:0] line_signed_energy_acc,
  output logic [AW-1:0] line_unsigned_energy_acc,
  output logic [2:0] zeroCrossEnable,
  output logic halfCycleFlag,
  output logic irq_n
);
  initial begin
    if (SW < 8 || AW < SW + 4) $error("rap_power_dsp: bad widths");
    if (SHIFT_DEPTH < 4) $error("rap_power_dsp: shift depth too small");
    if ((SHIFT_DEPTH & (SHIFT_DEPTH - 1)) != 0) $error("rap_power_dsp: depth not power of two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  wire reactiveMode = waveform_mode_ctrl[`RAP_REACTIVE_MODE_BIT];
  wire [1:0] sumModeBits =
    power_summing_mode_reg[`RAP_SUM_MODE_MSB:`RAP_SUM_MODE_LSB];
  rap_sum_mode_e sumMode;
  assign sumMode = rap_sum_mode_e'(sumModeBits);
  wire [2:0] lineSel = power_summing_mode_reg[`RAP_LINE_SEL_LSB+2:`RAP_LINE_SEL_LSB];
  wire [2:0] zxSel = measurement_mode_reg[`RAP_MEAS_MODE_ZX_LSB+2:`RAP_MEAS_MODE_ZX_LSB];

  function automatic logic signed [SW:0] magnitude(input logic signed [SW-1:0] v);
    magnitude = v[SW-1] ? -{v[SW-1], v} : {1'b0, v};
  endfunction : magnitude

  // Three-term combination per summing mode; used for reactive and active
  function automatic logic signed [SW+2:0] combine(
    input rap_sum_mode_e m, input logic [2:0] sel,
    input logic signed [SW-1:0] pa, input logic signed [SW-1:0] pb,
    input logic signed [SW-1:0] pc, input logic signed [SW-1:0] xab,
    input logic signed [SW-1:0] xcb);
    logic signed [SW+2:0] ta, tb, tc;
    ta = '0;
    tb = '0;
    tc = '0;
    unique case (m)
      RAP_SUM_ALL: begin
        ta = (SW+3)'(pa);
        tb = (SW+3)'(pb);
        tc = (SW+3)'(pc);
      end
      RAP_SUM_B_REF: begin
        ta = (SW+3)'(pa) - (SW+3)'(xab);
        tc = (SW+3)'(pc) - (SW+3)'(xcb);
      end
      RAP_SUM_B_REF_C: begin
        ta = (SW+3)'(pa) - (SW+3)'(xab);
        tc = (SW+3)'(pc);
      end
      default: begin
        ta = (SW+3)'(pa);
        tb = (SW+3)'(pb);
        tc = (SW+3)'(pc);
      end
    endcase
    combine = (sel[0] ? ta : '0) + (sel[1] ? tb : '0) + (sel[2] ? tc : '0);
  endfunction : combine

  ////////////////////////////////////////////////////////////////////////////
  // Phase shift: current samples written unchanged, read delayed
  logic [$clog2(SHIFT_DEPTH)-1:0] wrPtr_reg;
  logic [3*SW-1:0] shiftedCurr;
  logic signed [SW-1:0] varLpf_reg [3];
  logic signed [SW-1:0] varProd [3];
  logic signed [SW-1:0] crossAB [3];
  logic signed [SW-1:0] apComb [3];
  logic primed_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) wrPtr_reg <= '0;
    else if (sampleValid) wrPtr_reg <= wrPtr_reg + 1'b1;
  end
  // Memory slots hold nothing after reset; unknowns would stick in the
  // filter, so the shifted current reads as zero until all slots are written
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) primed_reg <= 1'b0;
    else if (sampleValid && wrPtr_reg == '1) primed_reg <= 1'b1;
  end
  wire [$clog2(SHIFT_DEPTH)-1:0] rdPtr = wrPtr_reg - shiftSlots;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gPhase
      wire signed [SW-1:0] v = voltSample[g*SW +: SW];
      wire signed [SW-1:0] iq = primed_reg ? shiftedCurr[g*SW +: SW] : '0;
      wire signed [SW-1:0] ib = primed_reg ? shiftedCurr[SW +: SW] : '0;
      wire signed [2*SW-1:0] prodFull = v * iq;
      wire signed [2*SW-1:0] crossFull = v * ib;
      assign varProd[g] = prodFull[2*SW-2 -: SW];
      assign crossAB[g] = crossFull[2*SW-2 -: SW];
      // Gain 800h halves the output, 7ffh gives about one and a half
      wire [SW-1:0] vr = voltRms[g*SW +: SW];
      wire [SW-1:0] ir = currRms[g*SW +: SW];
      wire [2*SW-1:0] vaFull = vr * ir;
      wire [SW-1:0] vaRaw = vaFull[2*SW-1 -: SW];
      wire signed [11:0] gn = apparentGain[g*12 +: 12];
      wire signed [SW+13:0] vaScaled =
        $signed({2'b00, vaRaw, 12'h000}) + $signed({1'b0, vaRaw}) * gn;
      assign apComb[g] = vaScaled[SW+`RAP_VA_GAIN_SHIFT-1 -: SW];
      rap_delay_line #(.WIDTH(SW), .DEPTH(SHIFT_DEPTH)) uShift (
        .clk_sys(clk_sys),
        .wrEn(sampleValid),
        .wrAddr(wrPtr_reg),
        .wrData(currSample[g*SW +: SW]),
        .rdAddr(rdPtr),
        .rdData(shiftedCurr[g*SW +: SW])
      );
      // First-order low pass; ripple traded for a cheap shift
      wire signed [SW:0] lpfStep = (SW+1)'(varProd[g]) - (SW+1)'(varLpf_reg[g]);
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) varLpf_reg[g] <= '0;
        else if (sampleValid) varLpf_reg[g] <= varLpf_reg[g] +
          SW'(lpfStep >>> `RAP_LPF_SHIFT);
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          reactivePower[g*SW +: SW] <= '0;
          apparentPower[g*SW +: SW] <= '0;
        end else begin
          reactivePower[g*SW +: SW] <= varLpf_reg[g];
          apparentPower[g*SW +: SW] <= apComb[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Totals
  wire signed [SW-1:0] actA = activeProd[0 +: SW];
  wire signed [SW-1:0] actB = activeProd[SW +: SW];
  wire signed [SW-1:0] actC = activeProd[2*SW +: SW];
  wire signed [SW+2:0] reactTotal = combine(sumMode, lineSel,
    varLpf_reg[0], varLpf_reg[1], varLpf_reg[2], crossAB[0], crossAB[2]);
  wire signed [SW+2:0] actTotal = combine(sumMode, lineSel, actA, actB, actC,
    '0, '0);
  // Unsigned accumulator cannot take signed sums, so magnitudes only
  wire [SW+2:0] actMagTotal = (lineSel[0] ? (SW+3)'(magnitude(actA)) : '0) +
    (lineSel[1] ? (SW+3)'(magnitude(actB)) : '0) +
    (lineSel[2] ? (SW+3)'(magnitude(actC)) : '0);
  // Apparent terms are magnitudes; widen without sign extension
  wire [SW+1:0] vaTotal = {2'b00, apComb[0]} + {2'b00, apComb[1]} +
    {2'b00, apComb[2]};
  // Reactive scaled by 1000/9546 so full-scale counts match
  wire signed [SW+18:0] reactScaledFull =
    (SW+19)'(reactTotal) * $signed({1'b0, `RAP_VAR_SCALE_NUM});
  wire signed [SW+2:0] reactScaled =
    (SW+3)'(reactScaledFull / $signed({1'b0, `RAP_VAR_SCALE_DEN}));

  wire signed [SW+2:0] signedAdd = reactiveMode ? reactScaled : actTotal;
  wire [SW+2:0] unsignedAdd = reactiveMode ? actMagTotal : (SW+3)'(vaTotal);

  ////////////////////////////////////////////////////////////////////////////
  // Half-cycle counting and accumulation
  wire [2:0] zxHit = zeroCross & zxSel;
  wire halfCycleTick = |zxHit;
  rap_acc_state_e state_reg;
  logic [15:0] halfCount_reg;
  logic signed [AW-1:0] signedAcc_reg;
  logic [AW-1:0] unsignedAcc_reg;
  wire periodDone = halfCycleTick && (halfCount_reg + 16'h0001 >= half_cycle_target);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) state_reg <= RAP_IDLE;
    else begin
      unique case (state_reg)
        RAP_IDLE: if (halfCycleTick) state_reg <= RAP_RUN;
        RAP_RUN: if (periodDone) state_reg <= RAP_DONE;
        RAP_DONE: state_reg <= RAP_RUN;
        default: state_reg <= RAP_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) halfCount_reg <= '0;
    else if (state_reg == RAP_DONE) halfCount_reg <= '0;
    else if (state_reg == RAP_RUN && halfCycleTick) halfCount_reg <= halfCount_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      signedAcc_reg <= '0;
      unsignedAcc_reg <= '0;
    end else if (state_reg == RAP_DONE) begin
      signedAcc_reg <= '0;
      unsignedAcc_reg <= '0;
    end else if (state_reg == RAP_RUN && sampleValid) begin
      signedAcc_reg <= signedAcc_reg + AW'(signedAdd);
      unsignedAcc_reg <= unsignedAcc_reg + AW'(unsignedAdd);
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_signed_energy_acc <= '0;
      line_unsigned_energy_acc <= '0;
    end else if (state_reg == RAP_RUN && periodDone) begin
      line_signed_energy_acc <= signedAcc_reg;
      line_unsigned_energy_acc <= unsignedAcc_reg;
    end
  end
  // Set beats clear in the same cycle
  wire flagNext = (state_reg == RAP_RUN && periodDone) ||
    (halfCycleFlag && !halfCycleFlagClr);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halfCycleFlag <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      halfCycleFlag <= flagNext;
      irq_n <= !(flagNext && halfCycleIrqEn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered status outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zeroCrossEnable <= 3'h0;
    end else begin
      zeroCrossEnable <= zxSel;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      totalApparent <= '0;
    end else begin
      totalApparent <= vaTotal;
    end
  end
endmodule : rap_power_dsp

// ==== src/rap_defs.svh ====
/*
  Offsets, field positions, reset values and counts for the reactive and
  apparent power block. Assumes inclusion by bare name from the package.
*/
`ifndef RAP_DEFS_SVH
`define RAP_DEFS_SVH
`define RAP_WAVEFORM_MODE_OFFSET 8'h0c
`define RAP_WAVEFORM_MODE_RESET 8'h00
`define RAP_REACTIVE_MODE_BIT 5
`define RAP_SUM_MODE_MSB 7
`define RAP_SUM_MODE_LSB 6
`define RAP_LINE_SEL_LSB 3
`define RAP_POWER_SUMMING_RESET 8'h3f
`define RAP_MEAS_MODE_ZX_LSB 4
`define RAP_MEAS_MODE_RESET 8'h70
`define RAP_HALF_CYCLE_RESET 16'hffff
`define RAP_PHASE_SHIFT_DEG 89
`define RAP_VAR_SCALE_NUM 16'd1000
`define RAP_VAR_SCALE_DEN 16'd9546
`define RAP_LPF_SHIFT 8
`define RAP_VA_GAIN_SHIFT 12
`define RAP_VA_GAIN_RESET 12'h000
`endif

// ==== src/rap_pkg.sv ====
/*
  Types shared by the reactive and apparent power block.
  Assumes the defines header sits beside it.
*/
`include "rap_defs.svh"
package rap_pkg;
  typedef enum logic [1:0] {
    RAP_SUM_ALL = 2'h0,
    RAP_SUM_B_REF = 2'h1,
    RAP_SUM_B_REF_C = 2'h2,
    RAP_SUM_RSVD = 2'h3
  } rap_sum_mode_e;
  typedef enum logic [1:0] {
    RAP_IDLE = 2'b00,
    RAP_RUN = 2'b01,
    RAP_DONE = 2'b11
  } rap_acc_state_e;
endpackage : rap_pkg

// ==== src/rap_delay_line.sv ====
/*
  Small sample memory used to delay current samples by a programmable
  number of sample slots. Assumes writes and reads come one per clock.
*/
`timescale 1ns/1ns
module rap_delay_line #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("rap_delay_line: bad size");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (wrEn) mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule : rap_delay_line

// ==== verification/rap_power_dsp_props.sv ====
/*
  Port checker for the reactive and apparent power block.
  Assumes it is bound to rap_power_dsp, one clock, async high reset.
*/
`timescale 1ns/1ns
module rap_power_dsp_props #(
  parameter int AW = 48
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] measurement_mode_reg,
  input wire logic halfCycleIrqEn,
  input wire logic halfCycleFlagClr,
  input wire logic [AW-1:0] line_signed_energy_acc,
  input wire logic [AW-1:0] line_unsigned_energy_acc,
  input wire logic [2:0] zeroCrossEnable,
  input wire logic halfCycleFlag,
  input wire logic irq_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_zx_enable_sel: assert property (!$past(rst) && $stable(measurement_mode_reg) |->
    zeroCrossEnable == measurement_mode_reg[6:4]) else $error("crossing enable mismatch");
  a_irq_on_flag: assert property ($rose(halfCycleFlag) && halfCycleIrqEn &&
    $stable(halfCycleIrqEn) |-> !irq_n) else $error("irq not raised at period end");
  a_irq_needs_flag: assert property (!irq_n |->
    halfCycleFlag || $past(halfCycleFlag)) else $error("irq low without flag");
  a_flag_holds: assert property (halfCycleFlag && !halfCycleFlagClr |=>
    halfCycleFlag) else $error("flag dropped without clear");
  a_signed_stands: assert property ($changed(line_signed_energy_acc) |->
    halfCycleFlag) else $error("signed result moved mid period");
  a_unsigned_stands: assert property ($changed(line_unsigned_energy_acc) |->
    halfCycleFlag) else $error("unsigned result moved mid period");
  a_flag_needs_sel: assert property ($rose(halfCycleFlag) |->
    $past(measurement_mode_reg[6:4]) != 3'h0) else $error("period end with no phase");
  a_reset_quiet: assert property ($fell(rst) |->
    irq_n && !halfCycleFlag) else $error("flag or irq after reset");
endmodule : rap_power_dsp_props
////////////////////////////////////////////////////////////////////////////////
bind rap_power_dsp rap_power_dsp_props #(.AW(AW)) u_props (.*);

// ==== verification/rap_power_dsp_tb_top.sv ====
/*
  Self-checking bench for rap_power_dsp.
  Assumes the design and checker files compile before it.
*/
`timescale 1ns/1ns
module rap_power_dsp_tb_top;
  localparam int SW = 24;
  localparam int AW = 48;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sampleValid = 1'b1;
  logic [3*SW-1:0] voltSample = '0, currSample = '0, activeProd = '0;
  logic [3*SW-1:0] voltRms = '0, currRms = '0, reactivePower, apparentPower, lo;
  logic [2:0] zeroCross = 3'h0;
  logic [5:0] shiftSlots = 6'h10;
  logic [7:0] waveform_mode_ctrl = 8'h00, power_summing_mode_reg = 8'h38;
  logic [7:0] measurement_mode_reg = 8'h10;
  logic [15:0] half_cycle_target = 16'h0003;
  logic [35:0] apparentGain = '0;
  logic halfCycleIrqEn = 1'b1, halfCycleFlagClr = 1'b0, halfCycleFlag, irq_n;
  logic [SW+1:0] totalApparent;
  logic [AW-1:0] line_signed_energy_acc, line_unsigned_energy_acc;
  logic [2:0] zeroCrossEnable;
  int fails = 0;
  int tests_run = 0;

  rap_power_dsp #(.SW(SW), .AW(AW), .SHIFT_DEPTH(64)) u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .sampleValid(sampleValid),
    .voltSample(voltSample),
    .currSample(currSample),
    .activeProd(activeProd),
    .voltRms(voltRms),
    .currRms(currRms),
    .zeroCross(zeroCross),
    .shiftSlots(shiftSlots),
    .waveform_mode_ctrl(waveform_mode_ctrl),
    .power_summing_mode_reg(power_summing_mode_reg),
    .measurement_mode_reg(measurement_mode_reg),
    .half_cycle_target(half_cycle_target),
    .apparentGain(apparentGain),
    .halfCycleIrqEn(halfCycleIrqEn),
    .halfCycleFlagClr(halfCycleFlagClr),
    .reactivePower(reactivePower),
    .apparentPower(apparentPower),
    .totalApparent(totalApparent),
    .line_signed_energy_acc(line_signed_energy_acc),
    .line_unsigned_energy_acc(line_unsigned_energy_acc),
    .zeroCrossEnable(zeroCrossEnable),
    .halfCycleFlag(halfCycleFlag),
    .irq_n(irq_n)
  );

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic test_done();
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic clr_flag();
    @(posedge clk_sys) halfCycleFlagClr <= 1'b1;
    @(posedge clk_sys) halfCycleFlagClr <= 1'b0;
    @(posedge clk_sys);
  endtask : clr_flag

  // Crossings every 8 cycles on phase A until the period closes
  task automatic run_period();
    int n;
    n = 0;
    while (halfCycleFlag !== 1'b1 && n < 400) begin
      @(posedge clk_sys) zeroCross <= (n % 8 == 0) ? 3'h1 : 3'h0;
      n++;
    end
    @(posedge clk_sys) zeroCross <= 3'h0;
    chk(halfCycleFlag === 1'b1, "period never ended");
  endtask : run_period

  // Two periods so the first, mixed with the old setup, is discarded
  task automatic setup(input logic [7:0] w, input logic [7:0] p,
                       input logic [3*SW-1:0] a, input logic [SW-1:0] v);
    @(posedge clk_sys);
    waveform_mode_ctrl <= w;
    power_summing_mode_reg <= p;
    activeProd <= a;
    voltSample <= {48'h0, v};
    currSample <= {48'h0, v};
    clr_flag();
    run_period();
    clr_flag();
    run_period();
  endtask : setup
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(irq_n === 1'b1 && halfCycleFlag === 1'b0, "reset irq/flag");
    chk(line_signed_energy_acc === '0, "reset signed acc");
  endtask : t_reset

  task automatic t_irq();
    setup(8'h00, 8'h38, 24'h0003e8, 24'h000000);
    chk(zeroCrossEnable === 3'h1, "crossing enable");
    chk(irq_n === 1'b0, "irq not low");
    @(posedge clk_sys) halfCycleIrqEn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(irq_n === 1'b1, "masked irq low");
    clr_flag();
    chk(halfCycleFlag === 1'b0, "flag not cleared");
    halfCycleIrqEn <= 1'b1;
  endtask : t_irq

  task automatic t_normal();
    @(posedge clk_sys) voltRms <= {3{24'h400000}};
    currRms <= {3{24'h400000}};
    setup(8'h00, 8'h38, 24'hfffc18, 24'h000000);
    chk(line_signed_energy_acc[AW-1] === 1'b1, "signed acc not negative");
    chk(line_unsigned_energy_acc !== '0, "apparent line acc empty");
  endtask : t_normal

  task automatic t_reactive();
    setup(8'h20, 8'h38, 24'hfffc18, 24'h000000);
    chk(line_signed_energy_acc === '0, "reactive acc not zero");
    chk(line_unsigned_energy_acc !== '0, "magnitude acc empty");
    setup(8'h20, 8'h38, 24'h000000, 24'h100000);
    chk(line_unsigned_energy_acc === '0, "apparent in unsigned");
    chk(line_signed_energy_acc[AW-1] === 1'b0, "reactive sign");
    chk(line_signed_energy_acc !== '0, "reactive acc empty");
    chk(reactivePower[SW-1] === 1'b0 && reactivePower[SW-1:0] !== '0, "phase sign");
  endtask : t_reactive

  task automatic t_select();
    setup(8'h00, 8'h00, 24'h0003e8, 24'h000000);
    chk(line_signed_energy_acc === '0, "deselected terms counted");
  endtask : t_select

  // Phase B strongly negative: of modes 0 to 2, only mode 0 lets it turn the sum negative
  task automatic t_modes();
    logic [AW-1:0] e;
    setup(8'h00, 8'h38, {24'h0003e8, 24'hffec78, 24'h0003e8}, 24'h000000);
    chk(line_signed_energy_acc[AW-1] === 1'b1, "mode 0 dropped phase B");
    setup(8'h00, 8'hb8, {24'h0003e8, 24'hffec78, 24'h0003e8}, 24'h000000);
    e = line_signed_energy_acc;
    chk(e[AW-1] === 1'b0 && e !== '0, "mode 2 kept phase B");
    setup(8'h00, 8'h78, {24'h0003e8, 24'hffec78, 24'h0003e8}, 24'h000000);
    e = line_signed_energy_acc;
    chk(e[AW-1] === 1'b0 && e !== '0, "mode 1 kept phase B");
  endtask : t_modes

  task automatic t_apparent();
    @(posedge clk_sys) voltRms <= {48'h0, 24'h400000};
    currRms <= '0;
    apparentGain <= {24'h0, 12'h800};
    repeat (20) @(posedge clk_sys);
    chk(apparentPower[SW-1:0] === '0, "offset with zero current");
    currRms <= {48'h0, 24'h400000};
    repeat (20) @(posedge clk_sys);
    lo = apparentPower;
    apparentGain <= {24'h0, 12'h7ff};
    repeat (20) @(posedge clk_sys);
    chk(apparentPower[SW-1:0] > lo[SW-1:0], "gain range order");
    chk(totalApparent === {2'b00, 24'h17ff00}, "total apparent sum");
  endtask : t_apparent
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    fails++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_irq();
    t_normal();
    t_reactive();
    t_select();
    t_modes();
    t_apparent();
    test_done();
  end
endmodule : rap_power_dsp_tb_top
